/* File: core/spn_mux_rx.sv */
`default_nettype none
// Checks received MUX primitives and fixes logical link alignment
module spn_mux_rx (
	input  wire logic ref_clk_in,
	input  wire logic reset_in,
	input  wire logic active_in,     // Receive checking enabled
	input  wire logic dw_valid_in,   // Dword strobe
	input  wire logic dw_ok_in,      // Dword decoded validly
	input  wire logic is_mux_in,     // Dword is a MUX primitive
	input  wire logic mux_link_in,   // Link number carried by MUX
	input  wire logic sync_lost_in,  // Dword sync lost
	output logic      aligned_out,   // First MUX seen
	output logic      cur_link_out,  // Logical link of current dword
	output logic      reset_req_out  // Link reset needed (pulse)
);
	import spn_pkg::*;
	logic aligned_reg, aligned_next;
	logic link_reg, link_next; // Link the next dword belongs to
	// Next-state logic for alignment tracking
	always_comb begin
		aligned_next  = aligned_reg;
		link_next     = link_reg;
		reset_req_out = 1'b0;
		if (!active_in) begin
			aligned_next = 1'b0;
			link_next    = 1'b0;
		end else if (aligned_reg && sync_lost_in) begin
			reset_req_out = 1'b1;
		end else if (dw_valid_in) begin
			if (!aligned_reg) begin
				if (dw_ok_in && is_mux_in) begin
					aligned_next = 1'b1;
					link_next    = ~mux_link_in;
				end
			end else begin
				link_next = ~link_reg;
				// Wrong marker for this slot forces a reset
				if (dw_ok_in && is_mux_in && mux_link_in != link_reg)
					reset_req_out = 1'b1;
				// Non-MUX or invalid dwords are dropped silently
			end
		end
	end
	// Register stage
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			aligned_reg <= 1'b0;
			link_reg    <= 1'b0;
		end else begin
			aligned_reg <= aligned_next;
			link_reg    <= link_next;
		end
	end
	assign aligned_out  = aligned_reg;
	assign cur_link_out = link_reg;
endmodule : spn_mux_rx
`default_nettype wire

/* File: core/spn_pkg.sv */
`default_nettype none
package spn_pkg;
	// Phy roles that shape hot-plug retry behaviour
	typedef enum logic [1:0] {
		SPN_ROLE_EXPANDER,
		SPN_ROLE_INITIATOR,
		SPN_ROLE_TARGET
	} spn_role_type;
	// Supported-settings vector, bit 5 is highest priority
	localparam int SPN_SET_W       = 6;
	localparam int SPN_BIT_G3_SSC  = 5;
	localparam int SPN_BIT_G3_NSSC = 4;
	localparam int SPN_BIT_G2_SSC  = 3;
	localparam int SPN_BIT_G2_NSSC = 2;
	localparam int SPN_BIT_G1_SSC  = 1;
	localparam int SPN_BIT_G1_NSSC = 0;
	// Rate codes for physical and logical link rates
	localparam logic [1:0] SPN_RATE_1G5 = 2'h0;
	localparam logic [1:0] SPN_RATE_3G  = 2'h1;
	localparam logic [1:0] SPN_RATE_6G  = 2'h2;
	// Window support mask positions
	localparam int SPN_WIN_1 = 0;
	localparam int SPN_WIN_2 = 1;
	localparam int SPN_WIN_3 = 2;
	// Number of MUX primitives in the multiplexing sequence
	localparam logic [2:0] SPN_MUX_COUNT = 3'h6;
	localparam int SPN_CNT_W = 16;
	// Hot-plug timeout, in microseconds, and clock rate
	localparam int SPN_HOTPLUG_US  = 10000;
	localparam int SPN_CLK_MHZ     = 100;
	localparam int SPN_HOTPLUG_CYC = SPN_HOTPLUG_US * SPN_CLK_MHZ;
endpackage : spn_pkg
`default_nettype wire

/* File: core/spn_seq.sv */
`default_nettype none
module spn_seq #(
	parameter int HOTPLUG_CYC = spn_pkg::SPN_HOTPLUG_CYC
) (
	input  wire logic                          ref_clk_in,
	input  wire logic                          reset_in,
	input  wire spn_pkg::spn_role_type         role_in,        // Phy role strap
	input  wire logic [2:0]                    win_support_in, // Supported windows mask
	input  wire logic [spn_pkg::SPN_SET_W-1:0] tx_set_in,      // Our settings bits
	input  wire logic [1:0]                    req_rate_in,    // Requested logical rate
	input  wire logic                          start_in,       // Begin phy reset
	input  wire logic                          wake_req_in,    // Leave low power
	// Window results from the phy
	input  wire logic                          win_done_in,    // Window ended (pulse)
	input  wire logic                          win_valid_in,
	input  wire logic                          win_idle_in,    // Line was D.C. idle
	input  wire logic [spn_pkg::SPN_SET_W-1:0] rx_set_in,      // Received settings
	input  wire logic                          rx_par_ok_in,   // Received parity good
	input  wire logic [1:0]                    phys_rate_in,   // Negotiated physical rate
	input  wire logic                          oob_det_in,     // OOB sequence detected
	input  wire logic                          comwake_det_in,
	input  wire logic                          align0_lock_in,
	input  wire logic                          align1_lock_in,
	// Receive dword stream
	input  wire logic                          dw_valid_in,
	input  wire logic                          dw_ok_in,
	input  wire logic                          is_mux_in,
	input  wire logic                          mux_link_in,
	input  wire logic                          sync_lost_in,
	output logic                               oob_start_out,  // Start OOB (pulse)
	output logic [2:0]                         win_run_out,    // Window one-hot being run
	output logic                               train_out,      // Running Train-SNW
	output logic                               final_out,      // Running Final-SNW
	output logic [spn_pkg::SPN_SET_W-1:0]      train_set_out,
	output logic                               send_mux_out,
	output logic                               mux_link_out,
	output logic                               no_delete_out,  // Suppress ALIGN insertion
	output logic                               send_comwake_out,
	output logic                               send_align0_out,
	output logic                               send_align1_out,
	output logic                               link_up_out,
	output logic                               mux_en_out,
	output logic                               rx_aligned_out,
	output logic                               rx_link_out,
	output logic [spn_pkg::SPN_CNT_W-1:0]      problem_cnt_out // Reset problem count
);
	import spn_pkg::*;
	typedef enum logic [3:0] {
		ST_IDLE, ST_OOB, ST_SNW1, ST_SNW2, ST_SNW3, ST_TRAIN, ST_FINAL,
		ST_MUX, ST_UP, ST_WAIT, ST_WAKE, ST_ALIGN0, ST_ALIGN1
	} spn_state_type;
	spn_state_type state_reg, state_next;
	logic [SPN_SET_W-1:0] tried_reg, tried_next;     // Settings already trained
	logic [SPN_SET_W-1:0] cur_set_reg, cur_set_next; // Setting in use
	logic [SPN_SET_W-1:0] rxs_reg, rxs_next;         // Latched far settings
	logic                 s1_act_reg, s1_act_next;   // SNW-1 line was not idle
	logic                 mux_reg, mux_next;
	logic [2:0]           mcnt_reg, mcnt_next;       // MUX primitives sent
	logic [31:0]          tmr_reg, tmr_next;         // Hot-plug timer
	logic                 tried_once_reg, tried_once_next;
	logic [SPN_CNT_W-1:0] pcnt_reg, pcnt_next;
	logic                 oob_reg, oob_next;
	logic                 pick_any;                  // Untried common left
	logic [SPN_SET_W-1:0] pick_set;
	logic                 mux_rst;                   // Receive side wants reset
	logic                 problem;                   // Reset problem this cycle
	logic                 mux_ok;                    // Rate pair allows multiplexing
	logic                 sup_ok;                    // Window mask is legal
	logic                 rx_sync;                   // Synchronised COMWAKE detect
	logic [1:0]           rx_sync1_reg, rx_sync2_reg;

	// Setting choice shared by every Train-SNW
	// At the SNW-3 result the far settings are not latched yet, so read them live
	spn_setting_pick u_pick (
		.tx_set_in (tx_set_in),
		.rx_set_in ((state_reg == ST_SNW3) ? rx_set_in : rxs_reg),
		.tried_in  (tried_reg),
		.any_out   (pick_any),
		.pick_out  (pick_set)
	);

	// Receive checker runs only in the MUX and link-up states, and only with multiplexing enabled
	spn_mux_rx u_mrx (
		.ref_clk_in    (ref_clk_in),
		.reset_in      (reset_in),
		.active_in     (mux_reg && (state_reg == ST_MUX || state_reg == ST_UP)),
		.dw_valid_in   (dw_valid_in),
		.dw_ok_in      (dw_ok_in),
		.is_mux_in     (is_mux_in),
		.mux_link_in   (mux_link_in),
		.sync_lost_in  (sync_lost_in),
		.aligned_out   (rx_aligned_out),
		.cur_link_out  (rx_link_out),
		.reset_req_out (mux_rst)
	);

	// Detector lines come from analog OOB logic: two-stage synchroniser
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rx_sync1_reg <= 2'h0;
			rx_sync2_reg <= 2'h0;
		end else begin
			rx_sync1_reg <= {oob_det_in, comwake_det_in};
			rx_sync2_reg <= rx_sync1_reg;
		end
	end
	assign rx_sync = rx_sync2_reg[0];

	// Illegal window masks (0 and 5) go to the wait state instead of SNW-1
	assign sup_ok = (win_support_in != 3'h0) && (win_support_in != 3'h5);

	// Multiplexing only for 1.5 on 3/6 or 3 on 6
	always_comb begin
		mux_ok = ((req_rate_in == SPN_RATE_1G5) && (phys_rate_in != SPN_RATE_1G5))
			|| ((req_rate_in == SPN_RATE_3G) && (phys_rate_in == SPN_RATE_6G));
	end

	// Main sequencing: one step per window result
	always_comb begin
		state_next      = state_reg;
		tried_next      = tried_reg;
		cur_set_next    = cur_set_reg;
		rxs_next        = rxs_reg;
		s1_act_next     = s1_act_reg;
		mux_next        = mux_reg;
		mcnt_next       = mcnt_reg;
		tmr_next        = tmr_reg;
		tried_once_next = tried_once_reg;
		pcnt_next       = pcnt_reg;
		oob_next        = 1'b0;
		problem         = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (start_in) begin
					oob_next   = 1'b1;
					state_next = ST_OOB;
				end else if (wake_req_in) begin
					tmr_next   = '0;
					state_next = ST_WAKE;
				end
			end
			ST_OOB: begin
				tried_next      = '0;
				mux_next        = 1'b0;
				tried_once_next = 1'b1;
				tmr_next        = '0;
				state_next      = ST_SNW1;
			end
			ST_SNW1: if (win_done_in) begin
				s1_act_next = !win_idle_in;
				state_next  = ST_SNW2;
			end
			ST_SNW2: if (win_done_in) begin
				// Active SNW-1 but idle SNW-2: far end went back to OOB
				if (s1_act_reg && win_idle_in)
					state_next = ST_WAIT;
				else
					state_next = ST_SNW3;
			end
			ST_SNW3: if (win_done_in) begin
				rxs_next = rx_set_in;
				if (win_valid_in && !rx_par_ok_in) begin
					problem = 1'b1;
				end else if (win_valid_in) begin
					mux_next   = mux_ok;
					state_next = ST_TRAIN;
				end else begin
					state_next = ST_FINAL;
				end
			end
			ST_TRAIN: if (win_done_in) begin
				if (win_valid_in) begin
					mcnt_next  = '0;
					state_next = mux_reg ? ST_MUX : ST_UP;
				end else if (pick_any) begin
					state_next = ST_TRAIN;
				end else begin
					problem = 1'b1;
				end
			end
			ST_FINAL: if (win_done_in) begin
				if (win_valid_in) begin
					mux_next   = 1'b0;
					state_next = ST_UP;
				end else begin
					problem = 1'b1;
				end
			end
			ST_MUX: begin
				mcnt_next = mcnt_reg + 3'h1;
				if (mcnt_reg == SPN_MUX_COUNT - 3'h1)
					state_next = ST_UP;
			end
			ST_UP: ;
			ST_WAIT: begin
				// Retry policy depends on role
				tmr_next = tmr_reg + 32'h1;
				if (role_in == SPN_ROLE_TARGET && tried_once_reg) begin
					state_next = ST_WAIT;
				end else if (tmr_reg >= 32'(HOTPLUG_CYC - 1)) begin
					oob_next   = 1'b1;
					state_next = ST_OOB;
				end
			end
			ST_WAKE: begin
				tmr_next = tmr_reg + 32'h1;
				if (rx_sync2_reg[1] || tmr_reg >= 32'(HOTPLUG_CYC - 1)) begin
					oob_next   = 1'b1;
					state_next = ST_OOB;
				end else if (rx_sync) begin
					state_next = ST_ALIGN0;
				end
			end
			ST_ALIGN0: if (align0_lock_in) state_next = ST_ALIGN1;
			ST_ALIGN1: if (align1_lock_in) state_next = ST_UP;
		endcase
		// Each Train-SNW consumes the chosen setting
		if (state_next == ST_TRAIN && (state_reg != ST_TRAIN || win_done_in)) begin
			cur_set_next = pick_set;
			tried_next   = tried_reg | pick_set;
		end
		if (problem) begin
			pcnt_next  = pcnt_reg + 1'b1;
			tmr_next   = '0;
			state_next = ST_WAIT;
		end
		// Receive MUX errors restart the link reset
		if (mux_rst) begin
			oob_next   = 1'b1;
			state_next = ST_OOB;
		end
		if (!sup_ok && state_next == ST_SNW1) begin
			state_next = ST_WAIT;
		end
	end

	// Registers of the sequencer
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state_reg      <= ST_IDLE;
			tried_reg      <= '0;
			cur_set_reg    <= '0;
			rxs_reg        <= '0;
			s1_act_reg     <= 1'b0;
			mux_reg        <= 1'b0;
			mcnt_reg       <= '0;
			tmr_reg        <= '0;
			tried_once_reg <= 1'b0;
			pcnt_reg       <= '0;
			oob_reg        <= 1'b0;
		end else begin
			state_reg      <= state_next;
			tried_reg      <= tried_next;
			cur_set_reg    <= cur_set_next;
			rxs_reg        <= rxs_next;
			s1_act_reg     <= s1_act_next;
			mux_reg        <= mux_next;
			mcnt_reg       <= mcnt_next;
			tmr_reg        <= tmr_next;
			tried_once_reg <= tried_once_next;
			pcnt_reg       <= pcnt_next;
			oob_reg        <= oob_next;
		end
	end

	// Outputs decoded from registered state
	assign oob_start_out    = oob_reg;
	assign win_run_out      = {state_reg == ST_SNW3, state_reg == ST_SNW2,
		state_reg == ST_SNW1};
	assign train_out        = state_reg == ST_TRAIN;
	assign final_out        = state_reg == ST_FINAL;
	assign train_set_out    = cur_set_reg;
	assign send_mux_out     = state_reg == ST_MUX;
	assign mux_link_out     = mcnt_reg[0];
	assign no_delete_out    = state_reg == ST_MUX;
	assign send_comwake_out = state_reg == ST_WAKE;
	assign send_align0_out  = state_reg == ST_ALIGN0;
	assign send_align1_out  = state_reg == ST_ALIGN1;
	assign link_up_out      = state_reg == ST_UP;
	assign mux_en_out       = mux_reg;
	assign problem_cnt_out  = pcnt_reg;

	// Exactly six MUX slots, links alternating from 0
	mux_six_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		$rose(send_mux_out) |-> !mux_link_out ##1 mux_link_out ##1 !mux_link_out
		##1 mux_link_out ##1 !mux_link_out ##1 mux_link_out ##1 !send_mux_out)
		else $error("mux sequence shape wrong");
	mux_gated_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		send_mux_out |-> mux_en_out) else $error("mux sent while disabled");
	mux_nogap_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(state_reg == ST_TRAIN && win_done_in && win_valid_in && mux_reg && !mux_rst)
		|=> send_mux_out) else $error("gap before mux");
	mux_nodel_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		send_mux_out |-> no_delete_out) else $error("deletables allowed");
	prob_count_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(problem && !mux_rst) |=> problem_cnt_out == $past(problem_cnt_out) + 1'b1)
		else $error("problem not counted");
	train_pick_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		$rose(train_out) |-> $onehot(train_set_out) &&
		((train_set_out & tx_set_in) != '0)) else $error("bad train set");
	mux_rst_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		mux_rst |=> oob_start_out) else $error("mux error not reset");
	wake_order_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		$rose(send_align1_out) |-> $past(send_align0_out))
		else $error("align1 before align0");
endmodule : spn_seq
`default_nettype wire

/* File: core/spn_setting_pick.sv */
`default_nettype none
// Picks the highest untried common setting (priority encoder)
module spn_setting_pick (
	input  wire logic [spn_pkg::SPN_SET_W-1:0] tx_set_in,
	input  wire logic [spn_pkg::SPN_SET_W-1:0] rx_set_in,
	input  wire logic [spn_pkg::SPN_SET_W-1:0] tried_in,
	output logic                               any_out,
	output logic [spn_pkg::SPN_SET_W-1:0]      pick_out
);
	import spn_pkg::*;
	logic [SPN_SET_W-1:0] avail; // Common and not yet tried
	// Highest bit wins: G3 SSC first, G1 no SSC last
	always_comb begin
		avail    = tx_set_in & rx_set_in & ~tried_in;
		pick_out = '0;
		for (int i = 0; i < SPN_SET_W; i++) begin
			if (avail[i]) begin
				pick_out = '0;
				pick_out[i] = 1'b1;
			end
		end
		any_out = |avail;
	end
endmodule : spn_setting_pick
`default_nettype wire

/* File: tb/sas_phy_speed_negotiation_mux_test.sv */
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
// Self-checking bench for the negotiation sequencer
module sas_phy_speed_negotiation_mux_test;
	timeunit 1ns;
	timeprecision 1ns;
	import spn_pkg::*;
	localparam int HP = 50;  // Short hot-plug timeout keeps the run brief
	logic ref_clk_in = 1'b0, reset_in = 1'b1, start_in = 1'b0, wake_req_in = 1'b0;
	logic oob_det_in = 1'b0, dw_valid_in = 1'b0, dw_ok_in = 1'b0, is_mux_in = 1'b0;
	logic mux_link_in = 1'b0, sync_lost_in = 1'b0, par = 1'b1, ans = 1'b1;
	spn_role_type role_in = SPN_ROLE_INITIATOR;
	logic [2:0] win_support_in = 3'h7;
	logic [5:0] tx_set_in = 6'h3f, rxs = 6'h3f, okset = 6'h3f;
	logic [1:0] req_rate_in = 2'h2, rate = 2'h2, dly = 2'h0, idle = 2'h0;
	logic [4:0] vld = 5'h1f;
	// Far-side answers
	logic win_done_in, win_valid_in, win_idle_in, rx_par_ok_in, comwake_det_in;
	logic align0_lock_in, align1_lock_in;
	logic [5:0] rx_set_in;
	logic [1:0] phys_rate_in;
	// Device outputs
	logic oob_start_out, train_out, final_out, send_mux_out, mux_link_out, no_delete_out;
	logic send_comwake_out, send_align0_out, send_align1_out, link_up_out, mux_en_out;
	logic rx_aligned_out, rx_link_out;
	logic [2:0] win_run_out;
	logic [5:0] train_set_out, rs, rem;
	logic [15:0] problem_cnt_out;
	int mismatches = 0, check_count = 0;
	bit h;
	logic lk;
	spn_seq #(.HOTPLUG_CYC(HP)) u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.role_in(role_in), .win_support_in(win_support_in), .tx_set_in(tx_set_in),
		.req_rate_in(req_rate_in), .start_in(start_in), .wake_req_in(wake_req_in),
		.win_done_in(win_done_in), .win_valid_in(win_valid_in), .win_idle_in(win_idle_in),
		.rx_set_in(rx_set_in), .rx_par_ok_in(rx_par_ok_in), .phys_rate_in(phys_rate_in),
		.oob_det_in(oob_det_in), .comwake_det_in(comwake_det_in), .dw_ok_in(dw_ok_in),
		.align0_lock_in(align0_lock_in), .align1_lock_in(align1_lock_in),
		.dw_valid_in(dw_valid_in), .is_mux_in(is_mux_in), .mux_link_in(mux_link_in),
		.sync_lost_in(sync_lost_in), .oob_start_out(oob_start_out), .train_out(train_out),
		.win_run_out(win_run_out), .final_out(final_out), .train_set_out(train_set_out),
		.send_mux_out(send_mux_out), .mux_link_out(mux_link_out), .mux_en_out(mux_en_out),
		.no_delete_out(no_delete_out), .send_comwake_out(send_comwake_out),
		.send_align0_out(send_align0_out), .send_align1_out(send_align1_out),
		.link_up_out(link_up_out), .rx_aligned_out(rx_aligned_out),
		.rx_link_out(rx_link_out), .problem_cnt_out(problem_cnt_out));
	spn_far_phy u_far (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .win_run_in(win_run_out),
		.train_in(train_out), .final_in(final_out), .train_set_in(train_set_out),
		.send_comwake_in(send_comwake_out), .send_align0_in(send_align0_out),
		.send_align1_in(send_align1_out), .dly_in(dly), .vld_in(vld), .idle_in(idle),
		.ok_set_in(okset), .par_in(par), .rx_set_in(rxs), .rate_in(rate), .ans_in(ans),
		.win_done_out(win_done_in), .win_valid_out(win_valid_in), .win_idle_out(win_idle_in),
		.rx_set_out(rx_set_in), .rx_par_ok_out(rx_par_ok_in), .phys_rate_out(phys_rate_in),
		.comwake_det_out(comwake_det_in), .align0_lock_out(align0_lock_in),
		.align1_lock_out(align1_lock_in));
	// Free-running 100 MHz clock
	initial begin
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	// Highest set bit: settings bits are already in priority order
	function automatic logic [5:0] hi(input logic [5:0] m);
		hi = 6'h00;
		for (int i = 0; i < 6; i++) if (m[i]) hi = 6'h01 << i;
	endfunction : hi
	// Multiplexing only on the listed rate pairs
	function automatic logic muxen(input logic [1:0] r, input logic [1:0] p);
		return (r == SPN_RATE_1G5 && p != SPN_RATE_1G5) || (r == SPN_RATE_3G && p == SPN_RATE_6G);
	endfunction : muxen
	// Conditions the bench can wait on
	function automatic logic pick(input int s);
		case (s)
			0: return link_up_out;
			1: return oob_start_out;
			2: return problem_cnt_out == 16'h0001;
			3: return problem_cnt_out == 16'h0002;
			4: return send_align0_out;
			5: return send_align1_out;
			6: return win_done_in && train_out;
			7: return final_out;
			8: return win_run_out[2];
			default: return |win_run_out;
		endcase
	endfunction : pick
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	// Bounded wait; running out is a failure only when the event is required
	task automatic wt(input int s, input int lim, input bit must, output bit hit);
		int n;
		n = 0;
		#1;
		hit = (pick(s) === 1'b1);
		while (!hit && n < lim) begin
			@(posedge ref_clk_in);
			#1;
			n++;
			hit = (pick(s) === 1'b1);
		end
		if (must && !hit) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, 0, 1);
			conclude();
		end
	endtask : wt
	// Two-cycle reset with fresh random defaults
	task automatic rst;
		@(posedge ref_clk_in);
		reset_in <= 1'b1;
		tx_set_in <= 6'($urandom) | 6'h01;
		rxs <= 6'($urandom) | 6'h01;
		dly <= 2'($urandom);
		{vld, okset, par, idle, ans, win_support_in} <= {5'h1f, 6'h3f, 1'b1, 2'h0, 1'b1, 3'h7};
		role_in <= SPN_ROLE_INITIATOR;
		{req_rate_in, rate} <= {2'h2, 2'h2};
		@(posedge ref_clk_in);
		#1;
		`CHK(problem_cnt_out, 16'h0000)
		`CHK(link_up_out, 1'b0)
		@(posedge ref_clk_in);
		reset_in <= 1'b0;
	endtask : rst
	// Start a phy reset and see the OOB pulse then SNW-1
	task automatic go;
		@(posedge ref_clk_in);
		start_in <= 1'b1;
		@(posedge ref_clk_in);
		start_in <= 1'b0;
		#1;
		`CHK(oob_start_out, 1'b1)
		@(posedge ref_clk_in);
		#1;
		`CHK(win_run_out, 3'h1)
	endtask : go
	// Full negotiation, watching the training pick and the MUX burst
	task automatic nego(input logic en);
		int n, k;
		logic pt;
		n = 0;
		k = 0;
		pt = 1'b0;
		go();
		while (link_up_out !== 1'b1 && n < 400) begin
			@(posedge ref_clk_in);
			#1;
			n++;
			if (train_out && !pt) `CHK(train_set_out, hi(tx_set_in & rxs))
			if (pt && !train_out) `CHK(send_mux_out, en)
			if (send_mux_out) `CHK(mux_link_out, k[0])
			if (send_mux_out) `CHK(no_delete_out, 1'b1)
			k = k + (send_mux_out ? 1 : 0);
			pt = train_out;
		end
		`CHK(k, en ? 6 : 0)
		`CHK(link_up_out, 1'b1)
		// A negotiation that never completes ends the run
		if (link_up_out !== 1'b1) conclude();
		`CHK(mux_en_out, en)
	endtask : nego
	// One received dword, strobe then release
	task automatic dwd(input logic ok, input logic mx, input logic lnk);
		@(posedge ref_clk_in);
		{dw_valid_in, dw_ok_in, is_mux_in, mux_link_in} <= {1'b1, ok, mx, lnk};
		@(posedge ref_clk_in);
		{dw_valid_in, dw_ok_in, is_mux_in, mux_link_in} <= {1'b0, ~ok, ~mx, ~lnk};
		#1;
	endtask : dwd
	initial begin
		void'($urandom(89688));
		// Every requested/physical rate pair
		for (int r = 0; r < 3; r++) for (int p = 0; p < 3; p++) begin
			rst();
			{req_rate_in, rate} <= {2'(r), 2'(p)};
			nego(muxen(2'(r), 2'(p)));
		end
		// Retrain down through every common setting
		rst();
		rs = 6'($urandom) | 6'h03;
		{tx_set_in, rxs, okset} <= {6'h3f, rs, 6'h01};
		go();
		rem = rs;
		while (rem != 6'h00) begin
			wt(6, 40, 1, h);
			`CHK(train_set_out, hi(rem))
			rem = rem & ~hi(rem);
			@(posedge ref_clk_in);
		end
		wt(0, 40, 1, h);
		// Each failure kind under each role
		for (int k = 0; k < 3; k++) for (int r = 0; r < 3; r++) begin
			rst();
			role_in <= spn_role_type'(r);
			if (k == 0) par <= 1'b0;
			if (k == 1) vld <= 5'h03;
			if (k == 2) okset <= 6'h00;
			go();
			if (k == 1) wt(7, 40, 1, h);
			wt(2, 200, 1, h);
			`CHK(link_up_out, 1'b0)
			wt(1, 2 * HP + 10, 0, h);
			`CHK(h, r != 2)
			if (h) wt(3, 200, 1, h);
		end
		// Idle SNW-2 after a live SNW-1 stops short of SNW-3
		rst();
		idle <= 2'h2;
		go();
		wt(8, 60, 0, h);
		`CHK(h, 1'b0)
		`CHK(problem_cnt_out, 16'h0000)
		// Illegal window masks never run a window
		for (int w = 0; w < 2; w++) begin
			rst();
			win_support_in <= (w == 0) ? 3'h0 : 3'h5;
			@(posedge ref_clk_in);
			start_in <= 1'b1;
			@(posedge ref_clk_in);
			start_in <= 1'b0;
			wt(9, 2 * HP, 0, h);
			`CHK(h, 1'b0)
		end
		// Received MUX alignment, then a wrong marker or lost sync
		for (int t = 0; t < 2; t++) begin
			rst();
			{req_rate_in, rate} <= {SPN_RATE_1G5, SPN_RATE_6G};
			nego(1'b1);
			lk = 1'($urandom);
			dwd(1'b1, 1'b0, lk);
			`CHK(rx_aligned_out, 1'b0)
			dwd(1'b0, 1'b1, lk);
			`CHK(rx_aligned_out, 1'b0)
			dwd(1'b1, 1'b1, lk);
			`CHK(rx_link_out, ~lk)
			dwd(1'b1, 1'b0, lk);
			`CHK(rx_link_out, lk)
			if (t == 0) begin
				dwd(1'b1, 1'b1, lk);
				wt(1, 3, 0, h);
				`CHK(h, 1'b0)
				dwd(1'b1, 1'b1, lk);
			end else begin
				@(posedge ref_clk_in);
				sync_lost_in <= 1'b1;
				@(posedge ref_clk_in);
				sync_lost_in <= 1'b0;
			end
			wt(1, 4, 1, h);
		end
		// Wake: answered, unanswered, and interrupted by OOB
		for (int t = 0; t < 3; t++) begin
			rst();
			ans <= (t == 0);
			@(posedge ref_clk_in);
			wake_req_in <= 1'b1;
			@(posedge ref_clk_in);
			wake_req_in <= 1'b0;
			#1;
			`CHK(send_comwake_out, 1'b1)
			if (t == 0) begin
				wt(4, 10, 1, h);
				`CHK(send_align1_out, 1'b0)
				wt(5, 10, 1, h);
				`CHK(send_align0_out, 1'b0)
				wt(0, 10, 1, h);
			end else if (t == 1) begin
				wt(1, HP - 5, 0, h);
				`CHK(h, 1'b0)
				wt(1, 20, 1, h);
			end else begin
				repeat (3) @(posedge ref_clk_in);
				oob_det_in <= 1'b1;
				@(posedge ref_clk_in);
				oob_det_in <= 1'b0;
				wt(1, 10, 1, h);
			end
		end
		conclude();
	end
endmodule : sas_phy_speed_negotiation_mux_test
`default_nettype wire

/* File: tb/spn_far_phy.sv */
`default_nettype none
// Attached phy model: closes each window after a delay and answers wake
module spn_far_phy (
	input  wire logic       ref_clk_in,
	input  wire logic       reset_in,
	input  wire logic [2:0] win_run_in,      // Window being run
	input  wire logic       train_in,
	input  wire logic       final_in,
	input  wire logic [5:0] train_set_in,
	input  wire logic       send_comwake_in,
	input  wire logic       send_align0_in,
	input  wire logic       send_align1_in,
	input  wire logic [1:0] dly_in,          // Extra cycles before a window ends
	input  wire logic [4:0] vld_in,          // SNW1..3 valid, bit 4 Final
	input  wire logic [1:0] idle_in,         // SNW1 and SNW2 idle
	input  wire logic [5:0] ok_set_in,       // Settings that train well
	input  wire logic       par_in,          // Parity seen on our bits
	input  wire logic [5:0] rx_set_in,       // Settings we advertise
	input  wire logic [1:0] rate_in,
	input  wire logic       ans_in,          // We answer COMWAKE
	output logic            win_done_out,
	output logic            win_valid_out,
	output logic            win_idle_out,
	output logic [5:0]      rx_set_out,
	output logic            rx_par_ok_out,
	output logic [1:0]      phys_rate_out,
	output logic            comwake_det_out,
	output logic            align0_lock_out,
	output logic            align1_lock_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_reg;   // Cycles spent in this window
	logic       done_reg;  // One-cycle end of window
	logic       act;       // Some window is running
	logic       v;         // Outcome of the running window
	assign act = (|win_run_in) | train_in | final_in;
	// Count out the window, then pulse once
	always_ff @(posedge ref_clk_in) begin
		if (reset_in || !act || done_reg) begin
			cnt_reg <= 2'h0;
			done_reg <= 1'b0;
		end else if (cnt_reg == dly_in) begin
			done_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 2'h1;
		end
	end
	// Training only succeeds on settings we can really lock on
	assign v = train_in ? |(train_set_in & ok_set_in) :
		final_in ? vld_in[4] : |(win_run_in & vld_in[2:0]);
	// Results are only good with the pulse; otherwise show inverted junk, idle held high
	assign win_done_out = done_reg;
	assign win_valid_out = done_reg ? v : ~v;
	assign win_idle_out = done_reg ? |(win_run_in[1:0] & idle_in) : 1'b1;
	assign rx_set_out = done_reg ? rx_set_in : ~rx_set_in;
	assign rx_par_ok_out = done_reg ? par_in : ~par_in;
	assign phys_rate_out = done_reg ? rate_in : ~rate_in;
	// Wake handshake from our side, one cycle behind the device
	always_ff @(posedge ref_clk_in) begin
		comwake_det_out <= !reset_in && send_comwake_in && ans_in;
		align0_lock_out <= !reset_in && send_align0_in;
		align1_lock_out <= !reset_in && send_align1_in;
	end
endmodule : spn_far_phy
`default_nettype wire
